// ---- design/asr_consts.svh ----
// Constants for the accelerometer serial readout block
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH
`define ASR_INSTR_ACCEL 8'h50
`define ASR_INSTR_TEMP 8'h54
`define ASR_INSTR_ADV4 8'h58
`define ASR_INSTR_ADV8 8'h78
`define ASR_INSTR_ADV2 8'h7C
`define ASR_ARG_BYTES_2 4'h2
`define ASR_ARG_BYTES_4 4'h4
`define ASR_ARG_BYTES_8 4'h8
`define ASR_SAMPLE_W 24
`define ASR_TEMP_W 14
`define ASR_FULL_POS 24'h6ACFC0
`define ASR_FULL_NEG 24'h95303F
`define ASR_RELOAD_CYCLES 8'h10
`define ASR_FIFO_DEPTH 8
`endif

// ---- design/asr_pkg.sv ----
// Types for the accelerometer serial readout block
package asr_pkg;
  typedef struct packed {
    logic [23:0] accel_word;
    logic [13:0] temp_word;
  } asr_sample_t;
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic ssb_n;
  } asr_link_in_t;
  typedef enum logic [3:0] {
    ASR_IDLE = 4'b0001,
    ASR_INSTR = 4'b0010,
    ASR_ARG = 4'b0100,
    ASR_DONE = 4'b1000
  } asr_state_t;
endpackage

// ---- design/asr_sync.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module asr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ---- design/asr_fifo.sv ----
// Sample FIFO with valid/ready on both sides
`timescale 1ns/1ps
module asr_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_reg];
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ---- design/asr_top.sv ----
// Accelerometer SPI slave readout: frame decode, response shift, status pins
`timescale 1ns/1ps
`include "asr_consts.svh"
// Function
// R1: SPI mode 0 slave only
// R2: MISO released while select high
// R3: Active-low select; respond only when low
// R4: Pulse ready pin per new sample
// R5: Reset reloads calibration data
// R6: Selfcheck output high when operating properly
// R7: Operate only while enable high
// R8: One instruction byte, 2/4/8 argument bytes
// R9: 0x50 returns 32-bit frame with sample
// R10: Only five instructions authorised
// R11: Frame carries ready and selfcheck bits
// R12: Sample is 24-bit two's complement
// R13: Compensated scale: 500000 counts per g
// R14: Compensation off gives raw samples
// R15: 2 micro-g LSB, clamp at 14 g
// R16: Ready bit held until sample read
// R17: Temperature unsigned 14 bits in two bytes
// R18: Selfcheck bit refreshed each sample
// R19: MSB first, one select-low transaction
// R20: Respond during argument; ignore others
module asr_top #(
  parameter int FIFO_DEPTH = `ASR_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ssb_n,
  output logic miso_out,
  output logic miso_oe,
  output logic sample_ready,
  output logic selfcheck_ok,
  input wire logic reset_n_reload,
  input wire logic enable,
  input wire logic accel_comp_on,
  input wire logic sample_valid,
  output logic sample_accept,
  input wire logic [23:0] sample_raw,
  input wire logic [13:0] temp_raw,
  input wire logic core_fault,
  output logic reload_busy
);
  // ------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------
  asr_pkg::asr_link_in_t link_s;
  logic [4:0] pins_q;
  asr_sync #(.WIDTH(5)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d({sclk, mosi, ~ssb_n, reset_n_reload, enable}),
    .q(pins_q)
  );
  logic rst_pin_n;
  logic en_s;
  // Select enters inverted so a cleared synchroniser reads deselected
  assign link_s = asr_pkg::asr_link_in_t'({pins_q[4:3], ~pins_q[2]}); // R3
  assign rst_pin_n = pins_q[1];
  assign en_s = pins_q[0];
  logic sclk_d_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic selected;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sclk_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= link_s.sclk;
    end
  end
  assign sclk_rise = link_s.sclk && !sclk_d_reg; // R1
  assign sclk_fall = !link_s.sclk && sclk_d_reg; // R1
  assign selected = !link_s.ssb_n && en_s; // R3 R7

  // ------------------------------------------------------------
  // Calibration reload after reset pin
  // ------------------------------------------------------------
  logic [7:0] reload_cnt_reg;
  always_ff @(posedge clock) begin
    if (!nrst) begin
      reload_cnt_reg <= `ASR_RELOAD_CYCLES;
    end else if (!rst_pin_n) begin
      reload_cnt_reg <= `ASR_RELOAD_CYCLES; // R5
    end else if (reload_cnt_reg != 8'h00) begin
      reload_cnt_reg <= reload_cnt_reg - 8'h01;
    end
  end
  assign reload_busy = (reload_cnt_reg != 8'h00);
  logic running;
  assign running = en_s && !reload_busy; // R7

  // ------------------------------------------------------------
  // Sample path: clamping and FIFO
  // ------------------------------------------------------------
  function automatic logic [23:0] asr_clamp(input logic [23:0] s);
    if (!s[23] && (s > `ASR_FULL_POS)) begin
      asr_clamp = `ASR_FULL_POS;
    end else if (s[23] && (s < `ASR_FULL_NEG)) begin
      asr_clamp = `ASR_FULL_NEG;
    end else begin
      asr_clamp = s;
    end
  endfunction
  asr_pkg::asr_sample_t fifo_in;
  asr_pkg::asr_sample_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  // Compensated input is already at 2 micro-g per count
  assign fifo_in.accel_word = accel_comp_on ? asr_clamp(sample_raw) : sample_raw; // R13 R14 R15
  assign fifo_in.temp_word = temp_raw; // R17
  assign sample_accept = running && fifo_in_ready;
  asr_fifo #(.WIDTH($bits(asr_pkg::asr_sample_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(sample_valid && running),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // ------------------------------------------------------------
  // Current sample, ready flag and status pins
  // ------------------------------------------------------------
  logic [23:0] cur_accel_reg;
  logic [13:0] cur_temp_reg;
  logic ready_bit_reg;
  logic selfcheck_reg;
  logic frame_busy;
  logic accel_read_done;
  // Refill only between frames so a shift never sees a torn word
  // Hold the slot until its sample has been read out
  assign fifo_pop = fifo_out_valid && !frame_busy && running && !ready_bit_reg; // R16
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cur_accel_reg <= 24'h000000;
      cur_temp_reg <= 14'h0000;
    end else if (fifo_pop) begin
      cur_accel_reg <= fifo_out.accel_word; // R12
      cur_temp_reg <= fifo_out.temp_word;
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ready_bit_reg <= 1'b0;
    end else if (fifo_pop) begin
      ready_bit_reg <= 1'b1; // R16
    end else if (accel_read_done) begin
      ready_bit_reg <= 1'b0; // R16
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      selfcheck_reg <= 1'b0;
    end else if (!running) begin
      selfcheck_reg <= 1'b0; // R6
    end else if (fifo_pop) begin
      selfcheck_reg <= !core_fault; // R6 R18
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sample_ready <= 1'b0;
    end else begin
      sample_ready <= fifo_pop; // R4
    end
  end
  assign selfcheck_ok = selfcheck_reg; // R6

  // ------------------------------------------------------------
  // Frame decoder
  // ------------------------------------------------------------
  function automatic logic [3:0] asr_arg_len(input logic [7:0] op);
    case (op)
      `ASR_INSTR_ACCEL: asr_arg_len = `ASR_ARG_BYTES_4;
      `ASR_INSTR_TEMP: asr_arg_len = `ASR_ARG_BYTES_2;
      `ASR_INSTR_ADV4: asr_arg_len = `ASR_ARG_BYTES_4;
      `ASR_INSTR_ADV8: asr_arg_len = `ASR_ARG_BYTES_8;
      `ASR_INSTR_ADV2: asr_arg_len = `ASR_ARG_BYTES_2;
      default: asr_arg_len = 4'h0;
    endcase
  endfunction
  asr_pkg::asr_state_t state_reg;
  logic [2:0] bit_cnt_reg;
  logic [3:0] byte_cnt_reg;
  logic [3:0] arg_len_reg;
  logic [7:0] instr_sr_reg;
  logic [7:0] opcode_reg;
  logic [63:0] tx_sr_reg;
  logic [7:0] instr_next;
  assign instr_next = {instr_sr_reg[6:0], link_s.mosi}; // R19
  assign frame_busy = (state_reg != asr_pkg::ASR_IDLE) || selected;
  assign accel_read_done = (state_reg == asr_pkg::ASR_ARG) && sclk_rise && selected
    && (opcode_reg == `ASR_INSTR_ACCEL) && (bit_cnt_reg == 3'h7)
    && (byte_cnt_reg == arg_len_reg - 4'h1);
  always_ff @(posedge clock) begin
    if (!nrst || !selected) begin
      state_reg <= asr_pkg::ASR_IDLE; // R3 R19
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 4'h0;
      arg_len_reg <= 4'h0;
      instr_sr_reg <= 8'h00;
      opcode_reg <= 8'h00;
    end else begin
      case (state_reg)
        asr_pkg::ASR_IDLE: begin
          state_reg <= asr_pkg::ASR_INSTR;
        end
        asr_pkg::ASR_INSTR: begin
          if (sclk_rise) begin
            instr_sr_reg <= instr_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              opcode_reg <= instr_next; // R8
              arg_len_reg <= asr_arg_len(instr_next);
              byte_cnt_reg <= 4'h0;
              if (asr_arg_len(instr_next) == 4'h0) begin
                state_reg <= asr_pkg::ASR_DONE; // R10 R20
              end else begin
                state_reg <= asr_pkg::ASR_ARG;
              end
            end
          end
        end
        asr_pkg::ASR_ARG: begin
          if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              byte_cnt_reg <= byte_cnt_reg + 4'h1;
              if (byte_cnt_reg == arg_len_reg - 4'h1) begin
                state_reg <= asr_pkg::ASR_DONE; // R8
              end
            end
          end
        end
        asr_pkg::ASR_DONE: begin
          state_reg <= asr_pkg::ASR_DONE;
        end
        default: begin
          state_reg <= asr_pkg::ASR_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Response shifter
  // ------------------------------------------------------------
  logic load_resp;
  assign load_resp = (state_reg == asr_pkg::ASR_INSTR) && sclk_rise && (bit_cnt_reg == 3'h7);
  always_ff @(posedge clock) begin
    if (!nrst || !selected) begin
      tx_sr_reg <= 64'h0;
    end else if (load_resp) begin
      case (instr_next)
        `ASR_INSTR_ACCEL: begin
          // Ready and selfcheck ride in the low byte
          tx_sr_reg <= {cur_accel_reg, 4'h0, ready_bit_reg, selfcheck_reg, 2'h0, 32'h0}; // R9 R11
        end
        `ASR_INSTR_TEMP: begin
          tx_sr_reg <= {cur_temp_reg, 2'h0, 48'h0}; // R17
        end
        default: begin
          tx_sr_reg <= 64'h0; // R20
        end
      endcase
    end else if ((state_reg == asr_pkg::ASR_ARG) && sclk_fall
        && !((byte_cnt_reg == 4'h0) && (bit_cnt_reg == 3'h0))) begin
      // First fall after the instruction presents the top bit, no shift
      tx_sr_reg <= {tx_sr_reg[62:0], 1'b0}; // R19
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      miso_oe <= 1'b0;
      miso_out <= 1'b0;
    end else begin
      miso_oe <= selected; // R2
      miso_out <= (state_reg == asr_pkg::ASR_ARG) && selected ? tx_sr_reg[63] : 1'b0; // R20
    end
  end
endmodule

// ---- dv/asr_properties.sv ----
// Port checker for the serial readout block
`timescale 1ns/1ps
module asr_properties #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ssb_n,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic sample_ready,
  input wire logic selfcheck_ok,
  input wire logic reset_n_reload,
  input wire logic enable,
  input wire logic accel_comp_on,
  input wire logic sample_valid,
  input wire logic sample_accept,
  input wire logic [23:0] sample_raw,
  input wire logic [13:0] temp_raw,
  input wire logic core_fault,
  input wire logic reload_busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  oe_sel_a: assert property (ssb_n [*4] |-> !miso_oe) else $error("oe while deselected");
  oe_en_a: assert property (!enable [*4] |-> !miso_oe) else $error("oe while disabled");
  miso_idle_a: assert property (ssb_n [*4] |-> !miso_out) else $error("miso busy");
  rdy_pulse_a: assert property (sample_ready |=> !sample_ready) else $error("ready long");
  accept_busy_a: assert property (reload_busy |-> !sample_accept) else $error("early");
  busy_hold_a: assert property ($rose(reload_busy) |-> reload_busy [*8]) else $error("short");
  busy_end_a: assert property ($rose(reload_busy) |-> ##[1:40] !reload_busy) else $error("hang");
  st_off_a: assert property (!enable [*4] |-> !selfcheck_ok) else $error("st while off");
  cover property (sample_ready);
  cover property ($fell(reload_busy));
  cover property (miso_oe && miso_out);
endmodule
bind asr_top asr_properties #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.*);

// ---- dv/asr_host.sv ----
// SPI master model, mode 0
`timescale 1ns/1ps
module asr_host (
  output logic sclk,
  output logic mosi,
  output logic ssb_n,
  input wire logic miso_out,
  input wire logic miso_oe
);
  logic last = 1'b0;
  wire miso = miso_oe ? miso_out : ~last;
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    ssb_n = 1'b1;
  end
  always @(posedge sclk) if (miso_oe) last <= miso_out;
  task automatic hold(input logic v);
    ssb_n = v;
  endtask
  task automatic xfer(input logic [7:0] ins, input int n, output logic [63:0] rx);
    logic [71:0] tx;
    tx = {ins, 64'h0};
    rx = 64'h0;
    ssb_n = 1'b0;
    #125;
    for (int i = 0; i < 8 * (n + 1); i++) begin
      mosi = tx[71-i];
      #62.5;
      sclk = 1'b1;
      if (i >= 8) rx = {rx[62:0], miso};
      #62.5;
      sclk = 1'b0;
    end
    mosi = ~mosi;
    #125;
    ssb_n = 1'b1;
  endtask
endmodule

// ---- dv/accel_spi_slave_readout_test.sv ----
// Self-checking bench for the serial readout block
`timescale 1ns/1ps
`include "asr_consts.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s expected %h seen %h", n, e, g); end end
module accel_spi_slave_readout_test;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic reset_n_reload = 1'b1;
  logic enable = 1'b1;
  logic accel_comp_on = 1'b0;
  logic sample_valid = 1'b0;
  logic [23:0] sample_raw = 24'h0;
  logic [13:0] temp_raw = 14'h0;
  logic core_fault = 1'b0;
  logic sclk, mosi, ssb_n, miso_out, miso_oe, sample_ready, selfcheck_ok;
  logic sample_accept, reload_busy;
  int mismatches = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h00012FF2;
  logic [63:0] rx;
  logic [23:0] q[$];
  logic [23:0] corner [4] = '{24'h7FFFFF, 24'h800000, 24'h6ACFC1, 24'h95303E};
  logic [7:0] ins [5] = '{8'h58, 8'h78, 8'h7C, 8'h51, 8'hFF};
  int len [5] = '{4, 8, 2, 4, 2};
  always #5 clock = ~clock;
  asr_top #(.FIFO_DEPTH(8)) uut (.clock, .nrst, .sclk, .mosi, .ssb_n, .miso_out, .miso_oe,
    .sample_ready, .selfcheck_ok, .reset_n_reload, .enable, .accel_comp_on, .sample_valid,
    .sample_accept, .sample_raw, .temp_raw, .core_fault, .reload_busy);
  asr_host host (.sclk, .mosi, .ssb_n, .miso_out, .miso_oe);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected read frame, clamped when compensation is on
  function automatic logic [31:0] efr(logic [23:0] a, logic c, r, s);
    logic [23:0] v;
    v = a;
    if (c && $signed(a) > $signed(`ASR_FULL_POS)) v = `ASR_FULL_POS;
    if (c && $signed(a) < $signed(`ASR_FULL_NEG)) v = `ASR_FULL_NEG;
    return {v, 4'h0, r, s, 2'h0};
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // 0: reload over, 1: ready pulse, 2: sample taken
  task automatic wait_for(input int w);
    int k;
    for (k = 0; k < 400; k++) begin
      @(posedge clock);
      if (w == 0 ? reload_busy === 1'b0 : w == 1 ? sample_ready === 1'b1 :
          sample_accept === 1'b1) break;
    end
    if (k == 400) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic push(input logic [23:0] a, input logic [13:0] t, input logic f, c);
    @(posedge clock);
    sample_raw <= a;
    temp_raw <= t;
    core_fault <= f;
    accel_comp_on <= c;
    sample_valid <= 1'b1;
    wait_for(2);
    sample_valid <= 1'b0;
  endtask
  task automatic gap();
    repeat (30) @(posedge clock);
  endtask
  initial begin
    logic [23:0] a;
    logic c, f;
    logic [31:0] r;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK("busy", 1'b1, reload_busy)
    `CHK("st", 1'b0, selfcheck_ok)
    wait_for(0);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      a = i < 4 ? corner[i] : r[31:8];
      c = i < 4 ? 1'b1 : r[0];
      f = r[1] & r[2];
      push(a, r[21:8], f, c);
      wait_for(1);
      host.xfer(8'h50, 4, rx);
      `CHK("accel", efr(a, c, 1'b1, ~f), rx[31:0])
      `CHK("st pin", ~f, selfcheck_ok)
      gap();
      host.xfer(8'h50, 4, rx);
      `CHK("reread", efr(a, c, 1'b0, ~f), rx[31:0])
      gap();
      host.xfer(8'h54, 2, rx);
      `CHK("temp", {r[21:8], 2'h0}, rx[15:0])
      gap();
    end
    $display("readout test done");
    for (int i = 0; i < 5; i++) begin
      host.xfer(ins[i], len[i], rx);
      `CHK("other", 64'h0, rx)
      gap();
    end
    $display("instruction test done");
    host.hold(1'b0);
    repeat (5) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      q.push_back(r[23:0]);
      push(r[23:0], 14'h0, 1'b0, 1'b0);
    end
    @(posedge clock);
    sample_valid <= 1'b1;
    @(posedge clock);
    `CHK("full", 1'b0, sample_accept)
    sample_valid <= 1'b0;
    host.hold(1'b1);
    while (q.size() > 0) begin
      wait_for(1);
      a = q.pop_front();
      host.xfer(8'h50, 4, rx);
      `CHK("drain", efr(a, 1'b0, 1'b1, 1'b1), rx[31:0])
    end
    $display("buffer test done");
    @(posedge clock);
    enable <= 1'b0;
    repeat (6) @(posedge clock);
    `CHK("st off", 1'b0, selfcheck_ok)
    enable <= 1'b1;
    reset_n_reload <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n_reload <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK("reload", 1'b1, reload_busy)
    wait_for(0);
    $display("pin test done");
    final_report();
  end
endmodule
